// [core/orient_pkg.sv]
package orient_pkg;
    // register byte offsets on the wishbone slave
    localparam logic [7:0] CTRL_OFF      = 8'h00; // control bits
    localparam logic [7:0] STATUS_OFF    = 8'h04; // status, read only
    localparam logic [7:0] ZONE_OFF      = 8'h08; // in-position zone width
    localparam logic [7:0] SHIFT_OFF     = 8'h0C; // position shift
    localparam logic [7:0] ENC_OFF       = 8'h10; // encoder pulses per rev
    localparam logic [7:0] GEAR_OFF      = 8'h14; // machine/motor teeth
    localparam logic [7:0] SERVO_OFF     = 8'h18; // p gain, comp gain
    localparam logic [7:0] INTEG_OFF     = 8'h1C; // integral time, ms
    localparam logic [7:0] LOOP_OFF      = 8'h20; // loop gain, decel ratio
    localparam logic [7:0] SWSPD_OFF     = 8'h24; // switchover speed
    localparam logic [7:0] BRAKE_OFF     = 8'h28; // brake time, display sel
    localparam logic [7:0] POS_OFF       = 8'h2C; // position count, read
    localparam logic [7:0] SPEED_OFF     = 8'h30; // measured speed, write
    // reset values
    localparam logic [15:0] ZONE_RST     = 16'h000B; // 11 counts
    localparam logic [15:0] SHIFT_RST    = 16'h0000;
    localparam logic [15:0] ENC_RST      = 16'h0400; // 1024 pulses
    localparam logic [15:0] GEAR_RST     = 16'h0001; // 1 tooth each
    localparam logic [15:0] PGAIN_RST    = 16'h003C; // 60
    localparam logic [15:0] INTEG_RST    = 16'h014D; // 0.333 s in ms
    localparam logic [15:0] COMP_RST     = 16'h0001; // 1
    localparam logic [15:0] LOOP_RST     = 16'h000A; // 10
    localparam logic [15:0] DECEL_RST    = 16'h0014; // 20
    localparam logic [15:0] SWSPD_RST    = 16'h00C8; // 200
    localparam logic [15:0] BTIME_RST    = 16'h0005; // brake time
    localparam logic [15:0] BTIME_EXT    = 16'h22B8; // 8888 external sel
    localparam logic [7:0]  DISP_POS     = 8'h13;    // 19 position monitor
    localparam logic [7:0]  DISP_RST     = 8'h00;
    // control and status bit positions
    localparam int CTRL_BRAKE_EN  = 0; // brake settings operate the brake
    localparam int CTRL_FAULT_CLR = 1; // write 1 clears encoder fault
    localparam int ST_ACTIVE  = 0;
    localparam int ST_DONE    = 1;
    localparam int ST_FAULT   = 2;
    localparam int ST_BRAKE   = 3;
    localparam int ST_PID_OFF = 4;
    localparam int ST_PI_MODE = 5;
    localparam int ST_POSCTL  = 6;
    // no-encoder watchdog: 100 ms at 20 MHz
    localparam int CLK_HZ        = 20_000_000;
    localparam int ENC_TMO_MS    = 100;
    localparam int ENC_TMO_CYC   = CLK_HZ / 1000 * ENC_TMO_MS;
    // orientation sequencer states
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_DECEL = 5'b00010,
        S_INDEX = 5'b00100,
        S_POS   = 5'b01000,
        S_HOLD  = 5'b10000
    } orient_state_e;
endpackage : orient_pkg

// [core/sync2.sv]
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for pin inputs, one per bit
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg; // first stage, read only by q_o
    // two stages, cleared by synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : sync2
`default_nettype wire

// [core/quad_counter.sv]
`timescale 1ns/1ns
`default_nettype none
// quadrature decoder: x4 counting of synchronised a/b phases
module quad_counter (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        a_i,      // synchronised phase a
    input  wire logic        b_i,      // synchronised phase b
    input  wire logic        clear_i,  // zero the count (index lock)
    output logic      [15:0] count_o,  // signed position count
    output logic             step_o    // pulse on any counted edge
);
    logic a_d_reg; // previous phase a
    logic b_d_reg; // previous phase b
    logic inc;     // forward edge
    logic dec;     // reverse edge
    // gray transition decoding
    always_comb begin
        inc = (a_i ^ a_d_reg ^ b_i ^ b_d_reg) & (a_i ^ b_d_reg);
        dec = (a_i ^ a_d_reg ^ b_i ^ b_d_reg) & ~(a_i ^ b_d_reg);
    end
    // previous phase capture
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            a_d_reg <= 1'b0;
            b_d_reg <= 1'b0;
        end else begin
            a_d_reg <= a_i;
            b_d_reg <= b_i;
        end
    end
    // count and step pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 16'h0000;
            step_o  <= 1'b0;
        end else begin
            step_o <= inc | dec;
            if (clear_i)
                count_o <= 16'h0000;
            else if (inc)
                count_o <= count_o + 16'h0001;
            else if (dec)
                count_o <= count_o - 16'h0001;
        end
    end
endmodule : quad_counter
`default_nettype wire

// [core/spindle_orientation_control.sv]
// Operation
// - done output when position inside target zone
// - zone width drives the done output and the entry to hold
// - shift offsets target by quadrature counts
// - servo parameters reset to documented defaults
// - comp gain zero selects pi control
// - switch to position at switchover speed
// - orientation ends when orient command drops
// - orientation forces brake despite external select
// - no completion while brake settings disable it
// - pid control disabled while orientation active
// - trip no-encoder fault when encoder silent
// - display select 19 shows position count
// - confirm index pulse before position control
`timescale 1ns/1ns
`default_nettype none
module spindle_orientation_control
    import orient_pkg::*;
#(
    parameter int ENC_TMO = orient_pkg::ENC_TMO_CYC // no-encoder timeout
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // encoder and command pins
    input  wire logic        enc_a_i,
    input  wire logic        enc_b_i,
    input  wire logic        enc_z_i,
    input  wire logic        orient_command_i,
    input  wire logic        forward_start_i,
    input  wire logic        reverse_start_i,
    input  wire logic        dc_brake_external_select_i,
    // drive outputs
    output logic             orient_done_output_o,
    output logic             no_encoder_fault_o,
    output logic             dc_brake_o,
    output logic             pid_enable_o,
    output logic             position_mode_o,
    output logic             pi_mode_o,
    output logic      [15:0] position_error_o,
    output logic      [15:0] display_data_o
);
    import orient_pkg::*;

    // refuse a timeout the watchdog counter cannot serve
    if (ENC_TMO < 1) begin : g_bad_tmo
        $error("ENC_TMO must be at least one cycle");
    end

    // synchronised pins
    logic [6:0] pins_s;
    logic a_s, b_s, z_s, ocmd_s, fwd_s, rev_s, bext_s;
    sync2 #(.W(7)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({enc_a_i, enc_b_i, enc_z_i, orient_command_i,
                 forward_start_i, reverse_start_i,
                 dc_brake_external_select_i}),
        .q_o   (pins_s)
    );
    assign {a_s, b_s, z_s, ocmd_s, fwd_s, rev_s, bext_s} = pins_s;

    // parameter registers
    logic        brake_en_reg;   // brake settings operate the brake
    logic [15:0] zone_reg;       // in-position zone, counts
    logic [15:0] shift_reg;      // position shift, counts
    logic [15:0] enc_reg;        // encoder pulses per rev
    logic [15:0] mgear_reg;      // machine side teeth
    logic [15:0] tgear_reg;      // motor side teeth
    logic [15:0] pgain_reg;      // speed p gain
    logic [15:0] comp_reg;       // lag/advance gain
    logic [15:0] integ_reg;      // integral time, ms
    logic [15:0] loop_reg;       // position loop gain
    logic [15:0] decel_reg;      // deceleration ratio
    logic [15:0] swspd_reg;      // switchover speed
    logic [15:0] btime_reg;      // dc brake time
    logic [7:0]  disp_reg;       // display select
    logic [15:0] speed_reg;      // measured speed from speed loop
    logic        fault_clr;      // write strobe clearing the fault

    // state
    orient_state_e state_reg, state_next;
    logic [15:0] pos_count;      // quadrature position
    logic        enc_step;       // encoder edge pulse
    logic        z_d_reg;        // previous index level
    logic        index_rise;     // index edge
    logic        lock_clear;     // zero counter at index
    logic        fault_reg;      // no-encoder trip
    logic [31:0] tmo_reg;        // silence counter
    logic [15:0] target;         // shifted target
    logic [15:0] diff;           // signed error
    logic [15:0] abs_diff;       // magnitude of error
    logic        in_zone;        // inside zone
    logic        brake_cfg_ok;   // brake settings operate
    logic        wb_req;         // valid bus cycle

    assign wb_req = cyc_i & stb_i & ~ack_o;

    // bus ack: one cycle after request, drops next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= wb_req;
    end

    // register writes, all fields whenever sel_i[0] is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brake_en_reg <= 1'b1;
            zone_reg     <= ZONE_RST;
            shift_reg    <= SHIFT_RST;
            enc_reg      <= ENC_RST;
            mgear_reg    <= GEAR_RST;
            tgear_reg    <= GEAR_RST;
            pgain_reg    <= PGAIN_RST;
            comp_reg     <= COMP_RST;
            integ_reg    <= INTEG_RST;
            loop_reg     <= LOOP_RST;
            decel_reg    <= DECEL_RST;
            swspd_reg    <= SWSPD_RST;
            btime_reg    <= BTIME_RST;
            disp_reg     <= DISP_RST;
            speed_reg    <= 16'h0000;
        end else if (wb_req && we_i && sel_i[0]) begin
            unique case (adr_i)
                CTRL_OFF:  brake_en_reg <= dat_i[CTRL_BRAKE_EN];
                ZONE_OFF:  zone_reg  <= dat_i[15:0];
                SHIFT_OFF: shift_reg <= dat_i[15:0];
                ENC_OFF:   enc_reg   <= dat_i[15:0];
                GEAR_OFF: begin
                    // values above 32767 are the writer's concern
                    mgear_reg <= dat_i[15:0];
                    tgear_reg <= dat_i[31:16];
                end
                SERVO_OFF: begin
                    pgain_reg <= dat_i[15:0];
                    comp_reg  <= dat_i[31:16];
                end
                INTEG_OFF: integ_reg <= dat_i[15:0];
                LOOP_OFF: begin
                    // range 5..20 and 5..50 is software's job
                    loop_reg  <= dat_i[15:0];
                    decel_reg <= dat_i[31:16];
                end
                SWSPD_OFF: swspd_reg <= dat_i[15:0];
                BRAKE_OFF: begin
                    btime_reg <= dat_i[15:0];
                    disp_reg  <= dat_i[23:16];
                end
                SPEED_OFF: speed_reg <= dat_i[15:0];
                default: ;                              // ignored
            endcase
        end
    end

    assign fault_clr = wb_req & we_i & sel_i[0] & (adr_i == CTRL_OFF)
                       & dat_i[CTRL_FAULT_CLR];

    // read mux, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (wb_req && !we_i) begin
            unique case (adr_i)
                CTRL_OFF:   dat_o <= {31'h0000_0000, brake_en_reg};
                STATUS_OFF: dat_o <= {25'h000_0000, position_mode_o,
                                      pi_mode_o, ~pid_enable_o,
                                      dc_brake_o, fault_reg,
                                      orient_done_output_o,
                                      state_reg != S_IDLE};
                ZONE_OFF:   dat_o <= {16'h0000, zone_reg};
                SHIFT_OFF:  dat_o <= {16'h0000, shift_reg};
                ENC_OFF:    dat_o <= {16'h0000, enc_reg};
                GEAR_OFF:   dat_o <= {tgear_reg, mgear_reg};
                SERVO_OFF:  dat_o <= {comp_reg, pgain_reg};
                INTEG_OFF:  dat_o <= {16'h0000, integ_reg};
                LOOP_OFF:   dat_o <= {decel_reg, loop_reg};
                SWSPD_OFF:  dat_o <= {16'h0000, swspd_reg};
                BRAKE_OFF:  dat_o <= {8'h00, disp_reg, btime_reg};
                POS_OFF:    dat_o <= {16'h0000, pos_count};
                SPEED_OFF:  dat_o <= {16'h0000, speed_reg};
                default:    dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // encoder counting, zeroed at the locked index
    quad_counter u_quad (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .a_i     (a_s),
        .b_i     (b_s),
        .clear_i (lock_clear),
        .count_o (pos_count),
        .step_o  (enc_step)
    );

    // index edge detect on the synchronised level
    always_ff @(posedge clk_i) begin
        if (rst_i)
            z_d_reg <= 1'b0;
        else
            z_d_reg <= z_s;
    end
    assign index_rise = z_s & ~z_d_reg;
    assign lock_clear = (state_reg == S_INDEX) & index_rise;

    // sequencer transitions
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE:  if (ocmd_s && !fault_reg)
                         state_next = S_DECEL;
            S_DECEL: if (speed_reg <= swspd_reg)
                         state_next = S_INDEX;
            S_INDEX: if (index_rise)
                         state_next = S_POS;
            S_POS:   if (in_zone)
                         state_next = S_HOLD;
            S_HOLD:  state_next = S_HOLD;
        endcase
        // command release ends at once, fault trips
        if (!ocmd_s || fault_reg)
            state_next = S_IDLE;
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i)
            state_reg <= S_IDLE;
        else
            state_reg <= state_next;
    end

    // no-encoder watchdog, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmo_reg   <= 32'h0000_0000;
            fault_reg <= 1'b0;
        end else begin
            if (!ocmd_s || enc_step || index_rise)
                tmo_reg <= 32'h0000_0000;
            else if (tmo_reg < 32'(ENC_TMO))
                tmo_reg <= tmo_reg + 32'h0000_0001;
            if (ocmd_s && tmo_reg == 32'(ENC_TMO - 1))
                fault_reg <= 1'b1;
            else if (fault_clr)
                fault_reg <= 1'b0;
        end
    end

    // target and zone test
    assign target   = shift_reg;
    assign diff     = pos_count - target;
    assign abs_diff = diff[15] ? 16'(~diff + 16'h0001) : diff;
    assign in_zone  = abs_diff <= zone_reg;
    assign brake_cfg_ok = brake_en_reg & (btime_reg != 16'h0000);

    // outputs from flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            orient_done_output_o <= 1'b0;
            no_encoder_fault_o   <= 1'b0;
            dc_brake_o           <= 1'b0;
            pid_enable_o         <= 1'b1;
            position_mode_o      <= 1'b0;
            pi_mode_o            <= 1'b0;
            position_error_o     <= 16'h0000;
            display_data_o       <= 16'h0000;
        end else begin
            // zone gates the flag and the entry to hold, servo error is unaffected
            orient_done_output_o <= (state_reg == S_HOLD) && in_zone
                                    && brake_cfg_ok;
            no_encoder_fault_o   <= fault_reg;
            // brake in hold, independent of external select
            if (state_reg == S_HOLD)
                dc_brake_o <= brake_cfg_ok;
            else if (btime_reg == BTIME_EXT)
                dc_brake_o <= 1'b0;
            else
                dc_brake_o <= 1'b0;
            pid_enable_o    <= (state_reg == S_IDLE);
            position_mode_o <= (state_reg == S_POS) ||
                               (state_reg == S_HOLD);
            pi_mode_o       <= (comp_reg == 16'h0000);
            position_error_o <= diff;
            display_data_o   <= (disp_reg == DISP_POS) ?
                                pos_count : 16'h0000;
        end
    end

    // external brake select drives nothing, only this unused sink
    logic unused_ok;
    assign unused_ok = bext_s & fwd_s & rev_s & |enc_reg & |mgear_reg
                       & |tgear_reg & |pgain_reg & |integ_reg
                       & |loop_reg & |decel_reg & |sel_i[3:1];
endmodule : spindle_orientation_control
`default_nettype wire

// [test/orient_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
// pin-level checker for the orientation block
module orient_monitor #(
    parameter int ENC_TMO = 50 // encoder silence limit, cycles
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic enc_z_i,
    input wire logic orient_command_i,
    input wire logic orient_done_output_o,
    input wire logic no_encoder_fault_o,
    input wire logic dc_brake_o,
    input wire logic pid_enable_o,
    input wire logic position_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [31:0] quiet_cnt; // cycles of encoder silence while orienting
    logic [2:0]  enc_prev;  // last phase levels

    // silence counter, restarts on any phase change
    always_ff @(posedge clk_i) begin
        if (rst_i || !orient_command_i ||
            {enc_a_i, enc_b_i, enc_z_i} != enc_prev) begin
            quiet_cnt <= '0;
        end else begin
            quiet_cnt <= quiet_cnt + 32'd1;
        end
        enc_prev <= {enc_a_i, enc_b_i, enc_z_i};
    end

    // request taken, then a one-cycle answer
    sequence bus_req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence ack_pulse_s;
        ack_o ##1 !ack_o;
    endsequence

    chk_ack_one_cycle: assert property (bus_req_s |=> ack_pulse_s)
        else $error("ack not a single pulse after request");
    chk_ack_unasked: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    chk_pid_posmode: assert property (
        position_mode_o |-> !pid_enable_o)
        else $error("pid on in position mode");
    chk_done_posmode: assert property (orient_done_output_o |->
        (position_mode_o && !pid_enable_o))
        else $error("done outside position control");
    chk_done_brake: assert property (
        orient_done_output_o |-> dc_brake_o)
        else $error("done without brake");
    chk_brake_orient: assert property (dc_brake_o |-> !pid_enable_o)
        else $error("brake outside orientation");
    chk_orient_end: assert property ($fell(orient_command_i) |->
        ##[1:5] (!orient_done_output_o && !position_mode_o && pid_enable_o))
        else $error("orientation did not end");
    chk_fault_quiet: assert property ($rose(no_encoder_fault_o) |->
        (quiet_cnt + 32'd8 >= ENC_TMO))
        else $error("fault before encoder silence limit");
endmodule : orient_monitor
`default_nettype wire

// [test/enc_model.sv]
`timescale 1ns/1ns
`default_nettype none
// quadrature encoder with index, phase a leads b going forward
module enc_model (
    input  wire logic clk_i,
    input  wire logic step_i,  // advance one count
    input  wire logic index_i, // raise the index phase
    output logic      a_o,
    output logic      b_o,
    output logic      z_o
);
    logic [1:0] ph_reg; // quarter-cycle position

    // one gray step per request keeps a single edge per count
    always_ff @(posedge clk_i) begin
        if (step_i) begin
            ph_reg <= ph_reg + 2'd1;
        end
        z_o <= index_i;
    end
    initial ph_reg = 2'd0;
    initial z_o = 1'b0;
    assign a_o = ph_reg[1] ^ ph_reg[0];
    assign b_o = ph_reg[1];
endmodule : enc_model
`default_nettype wire

// [test/spindle_orientation_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module spindle_orientation_control_tb;
    import orient_pkg::*;
    localparam int ENC_TMO = 400; // short silence limit for sim
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0]  adr_i = '0;
    logic [3:0]  sel_i = '0;
    logic [31:0] dat_i = '0, dat_o, rd;
    logic ack_o, enc_a_i, enc_b_i, enc_z_i, step = 0, index = 0;
    logic orient = 0, fwd = 0, rev = 0, ext = 0;
    logic done, fault, brake, pid, posm, pim;
    logic [15:0] perr, disp;
    int mismatches = 0;
    int total_checks = 0;

    always #25 clk_i = ~clk_i;

    spindle_orientation_control #(.ENC_TMO(ENC_TMO)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .enc_a_i(enc_a_i),
        .enc_b_i(enc_b_i), .enc_z_i(enc_z_i), .orient_command_i(orient),
        .forward_start_i(fwd), .reverse_start_i(rev),
        .dc_brake_external_select_i(ext), .orient_done_output_o(done),
        .no_encoder_fault_o(fault), .dc_brake_o(brake),
        .pid_enable_o(pid), .position_mode_o(posm), .pi_mode_o(pim),
        .position_error_o(perr), .display_data_o(disp));
    enc_model i_enc (.clk_i(clk_i), .step_i(step), .index_i(index),
        .a_o(enc_a_i), .b_o(enc_b_i), .z_o(enc_z_i));

    // counts, verdict, end of run
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge clk_i);
    endtask : tick
    // one classic cycle, held until ack is sampled
    task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
        sel_i <= 4'hF;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) begin
            mismatches++;
            $display("ERROR bus ack timeout");
            summarize();
        end
        rd = dat_o;
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
    endtask : wb
    task automatic rdchk(string nm, logic [7:0] a, logic [31:0] e);
        wb(0, a, '0);
        chk(nm, e, rd);
    endtask : rdchk
    task automatic move(int n);
        repeat (n) begin
            @(posedge clk_i); step <= 1;
            @(posedge clk_i); step <= 0;
            tick(2);
        end
    endtask : move
    task automatic pulse_index;
        @(posedge clk_i); index <= 1;
        tick(3); index <= 0;
        tick(4);
    endtask : pulse_index
    // orient, refuse above switchover, lock on index at switchover
    task automatic start_orient;
        wb(1, SPEED_OFF, {16'h0000, SWSPD_RST + 16'h0001});
        @(posedge clk_i); orient <= 1; fwd <= 1;
        tick(6);
        chk("pid", 0, pid);
        pulse_index();
        chk("posmode fast", 0, posm);
        wb(1, SPEED_OFF, {16'h0000, SWSPD_RST});
        move(3);
        chk("posmode no index", 0, posm);
        pulse_index();
        chk("posmode", 1, posm);
    endtask : start_orient
    // start released first, then the command
    task automatic end_orient;
        @(posedge clk_i); fwd <= 0;
        tick(2); orient <= 0;
        tick(6);
        chk("end done", 0, done);
        chk("end posmode", 0, posm);
        chk("end pid", 1, pid);
        chk("end brake", 0, brake);
    endtask : end_orient

    localparam logic [7:0] RA [10] = '{ZONE_OFF, SHIFT_OFF, ENC_OFF,
        GEAR_OFF, SERVO_OFF, INTEG_OFF, LOOP_OFF, SWSPD_OFF, BRAKE_OFF,
        8'hFC};
    localparam logic [31:0] RV [10] = '{{16'h0, ZONE_RST},
        {16'h0, SHIFT_RST}, {16'h0, ENC_RST}, {GEAR_RST, GEAR_RST},
        {COMP_RST, PGAIN_RST}, {16'h0, INTEG_RST}, {DECEL_RST, LOOP_RST},
        {16'h0, SWSPD_RST}, {8'h0, DISP_RST, BTIME_RST}, 32'h0000_0000};

    // main sequence
    initial begin
        tick(4); rst_i <= 0;
        for (int i = 0; i < 10; i++) rdchk("reset reg", RA[i], RV[i]);
        chk("pid idle", 1, pid);
        wb(1, GEAR_OFF, {16'd1540, 16'd3870});
        rdchk("gear", GEAR_OFF, {16'd1540, 16'd3870});
        wb(1, LOOP_OFF, {16'd50, 16'd5});
        rdchk("loop", LOOP_OFF, {16'd50, 16'd5});
        wb(1, SERVO_OFF, {16'h0000, PGAIN_RST}); tick(2);
        chk("pi sel", 1, pim);
        wb(1, SERVO_OFF, {COMP_RST, PGAIN_RST}); tick(2);
        chk("lag sel", 0, pim);
        $display("test config done");
        wb(1, SHIFT_OFF, 32'd30);
        wb(1, BRAKE_OFF, {8'h0, DISP_POS, BTIME_EXT});
        start_orient();
        move(10); tick(4);
        chk("done far", 0, done);
        chk("pos error", 32'h0000_FFEC, perr);
        move(20); tick(6);
        chk("done", 1, done);
        chk("brake", 1, brake);
        chk("pos error zero", 0, perr);
        chk("display", 30, disp);
        wb(1, ZONE_OFF, 32'd2); move(5); tick(6);
        chk("done out zone", 0, done);
        chk("posmode kept", 1, posm);
        wb(1, ZONE_OFF, 32'd5); tick(3);
        chk("done zone edge", 1, done);
        end_orient();
        $display("test orientation done");
        wb(1, BRAKE_OFF, 32'h0); wb(1, ZONE_OFF, {16'h0, ZONE_RST});
        start_orient();
        move(30); tick(6);
        chk("done no brake", 0, done);
        chk("display off", 0, disp);
        wb(1, BRAKE_OFF, {16'h0, BTIME_RST}); tick(4);
        chk("done brake on", 1, done);
        end_orient();
        $display("test brake setting done");
        @(posedge clk_i); orient <= 1;
        tick(ENC_TMO - 20);
        chk("fault early", 0, fault);
        tick(40);
        chk("fault", 1, fault);
        orient <= 0; tick(6);
        wb(1, CTRL_OFF, 32'h0000_0003); tick(2);
        chk("fault clear", 0, fault);
        $display("test encoder fault done");
        summarize();
    end
    initial begin
        tick(60000);
        mismatches++;
        $display("ERROR run timeout");
        summarize();
    end
endmodule : spindle_orientation_control_tb

bind spindle_orientation_control orient_monitor #(.ENC_TMO(ENC_TMO)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .ack_o(ack_o), .enc_a_i(enc_a_i), .enc_b_i(enc_b_i),
    .enc_z_i(enc_z_i), .orient_command_i(orient_command_i),
    .orient_done_output_o(orient_done_output_o),
    .no_encoder_fault_o(no_encoder_fault_o), .dc_brake_o(dc_brake_o),
    .pid_enable_o(pid_enable_o), .position_mode_o(position_mode_o));
`default_nettype wire
